/* hw/hps_home_preset.sv */
// Home preset sequencer: button arming sequence, status lamp, remote teaching
// commands over an Avalon-MM slave, and the home commit to non-volatile memory.
// Assumes all inputs are synchronous to core_clk_in and the NVM accepts a
// one-cycle write strobe at any time.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
module hps_home_preset #(
  parameter int unsigned CNT_W     = 28,
  parameter int unsigned HOLD_CYC  = hps_pkg::HOLD_MS * hps_pkg::CYC_PER_MS,
  parameter int unsigned WIN_CYC   = hps_pkg::WIN_MS * hps_pkg::CYC_PER_MS,
  parameter int unsigned BLINK_CYC = hps_pkg::BLINK_MS * hps_pkg::CYC_PER_MS,
  parameter int unsigned SHOW_CYC  = hps_pkg::SHOW_MS * hps_pkg::CYC_PER_MS
) (
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        btn_in,
  input  wire logic        nvm_has_home_in,
  input  wire logic [31:0] motor_pos_in,
  output logic             nvm_wr_out,
  output logic [31:0]      nvm_data_out,
  output logic             pos_zero_out,
  output logic             jog_step_out,
  output logic             jog_run_out,
  output logic             jog_dir_out,
  output logic             jog_fast_out,
  output logic [31:0]      jog_travel_out,
  output logic             stop_out,
  output logic             excite_off_out,
  output logic             status_lamp_red_out,
  output logic             status_lamp_green_out
);

  // Refuse periods that the timer width cannot hold.
  if (HOLD_CYC < 1 || WIN_CYC < 1 || BLINK_CYC < 1 || SHOW_CYC < 1)
    $error("hps_home_preset: every period needs at least one cycle");
  if (WIN_CYC >= (64'h1 << CNT_W) || HOLD_CYC >= (64'h1 << CNT_W) ||
      SHOW_CYC >= (64'h1 << CNT_W) || BLINK_CYC >= (64'h1 << CNT_W))
    $error("hps_home_preset: CNT_W too narrow for the periods");

  hps_pkg::hps_seq_t seq_q;      // Button sequencer state.
  hps_pkg::hps_seq_t seq_d;      // Its next value.
  logic [CNT_W-1:0]  lim;        // Limit for the current state.
  logic              tmr_done;   // Current state's period elapsed.
  logic              btn_commit; // Second press inside the window.
  logic              commit;     // Home commit from either method.
  logic              acc;        // Bus access completes this edge.
  logic              wr_acc;     // A write completes this edge.
  logic [2:0]        ctrl_q;     // Control register.
  logic [31:0]       travel_q;   // Minimum travel amount.
  logic [31:0]       home_q;     // Last committed home position.
  logic              home_vld_q; // A home exists.
  logic [CNT_W-1:0]  blink_q;    // Blink half-period counter.
  logic              phase_q;    // Blink phase.
  logic [31:0]       rd;         // Read mux.
  logic [5:0]        cmd;        // Command strobes of this write.

  // Bus answers one cycle after the request is seen.
  assign acc    = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
  assign wr_acc = acc && avs_write_in;
  assign cmd    = (wr_acc && avs_address_in == hps_pkg::OFS_CMD) ?
                  avs_writedata_in[5:0] : 6'h00;

  // The waitrequest flop drops for one cycle once a request has been seen.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      avs_waitrequest_out <= 1'b1;
    else
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
  end

  // Read data is loaded together with the drop of waitrequest.
  always_comb
  begin
    rd = 32'h0000_0000;
    case (avs_address_in)
      hps_pkg::OFS_CTRL:   rd = {29'h0000_0000, ctrl_q};
      hps_pkg::OFS_STATUS:
      begin
        rd[hps_pkg::ST_HOME]  = home_vld_q;
        rd[hps_pkg::ST_RUN]   = jog_run_out;
        rd[hps_pkg::ST_ARMED] = (seq_q == hps_pkg::SQ_REL) || (seq_q == hps_pkg::SQ_PRESS);
        rd[hps_pkg::ST_FREE]  = excite_off_out;
      end
      hps_pkg::OFS_TRAVEL: rd = travel_q;
      hps_pkg::OFS_HOME:   rd = home_q;
      // Unmapped and write-only offsets read as zero.
      default:             rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      avs_readdata_out <= 32'h0000_0000;
    else if (avs_read_in && avs_waitrequest_out)
      avs_readdata_out <= rd;
  end

  // Control and travel registers; command offset writes become strobes, writes elsewhere are dropped silently.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctrl_q   <= 3'h0;
      travel_q <= hps_pkg::TRAVEL_RST;
    end
    else if (wr_acc)
    begin
      if (avs_address_in == hps_pkg::OFS_CTRL)
        ctrl_q <= avs_writedata_in[2:0];
      if (avs_address_in == hps_pkg::OFS_TRAVEL)
        travel_q <= avs_writedata_in;
    end
  end

  // One timer serves every sequencer state; it restarts on each state change.
  always_comb
  begin
    case (seq_q)
      hps_pkg::SQ_HOLD:  lim = CNT_W'(HOLD_CYC);
      hps_pkg::SQ_SHOW:  lim = CNT_W'(SHOW_CYC);
      default:           lim = CNT_W'(WIN_CYC);
    endcase
  end

  hps_timer #(
    .CNT_W       (CNT_W)
  ) u_timer (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .clr_in      (seq_d != seq_q),
    .lim_in      (lim),
    .done_out    (tmr_done)
  );

  assign btn_commit = (seq_q == hps_pkg::SQ_PRESS) && btn_in && !tmr_done; // see [RULE2]
  assign commit     = btn_commit || (cmd[hps_pkg::CMD_PRESET] && ctrl_q[hps_pkg::CTRL_TEACH]);

  // Button sequencer next state.
  always_comb
  begin
    seq_d = seq_q;
    case (seq_q)
      hps_pkg::SQ_IDLE:
        if (btn_in)
          seq_d = hps_pkg::SQ_HOLD;
      hps_pkg::SQ_HOLD:
        if (!btn_in)
          seq_d = hps_pkg::SQ_IDLE;
        else if (tmr_done)
          seq_d = hps_pkg::SQ_REL;            // see [RULE1]
      hps_pkg::SQ_REL:
        if (!btn_in && !tmr_done)
          seq_d = hps_pkg::SQ_PRESS;          // see [RULE2]
        else if (tmr_done)
          seq_d = hps_pkg::SQ_LOCK;           // see [RULE4]
      hps_pkg::SQ_PRESS:
        if (btn_commit)
          seq_d = hps_pkg::SQ_SHOW;           // see [RULE2]
        else if (tmr_done)
          seq_d = hps_pkg::SQ_IDLE;           // see [RULE4]
      hps_pkg::SQ_SHOW:
        if (tmr_done)
          seq_d = hps_pkg::SQ_LOCK;           // see [RULE3]
      hps_pkg::SQ_LOCK:
        // A held button must come up before a fresh hold can count.
        if (!btn_in)
          seq_d = hps_pkg::SQ_IDLE;           // see [RULE4]
      default:
        seq_d = hps_pkg::SQ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      seq_q <= hps_pkg::SQ_IDLE;
    else
      seq_q <= seq_d;
  end

  // Free-running blink phase shared by arming and remote teaching.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      blink_q <= '0;
      phase_q <= 1'b0;
    end
    else if (blink_q >= CNT_W'(BLINK_CYC - 1))
    begin
      blink_q <= '0;
      phase_q <= !phase_q;
    end
    else
      blink_q <= blink_q + CNT_W'(1);
  end

  // Lamp: blink both while armed or teaching, both steady on a button commit, else green.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      status_lamp_red_out   <= 1'b0;
      status_lamp_green_out <= 1'b1;
    end
    else if (seq_d == hps_pkg::SQ_SHOW)
    begin
      status_lamp_red_out   <= 1'b1;              // see [RULE3]
      status_lamp_green_out <= 1'b1;
    end
    else if (seq_d == hps_pkg::SQ_REL || seq_d == hps_pkg::SQ_PRESS ||
             ctrl_q[hps_pkg::CTRL_TEACH])
    begin
      status_lamp_red_out   <= phase_q;           // see [RULE1] see [RULE7]
      status_lamp_green_out <= phase_q;
    end
    else
    begin
      status_lamp_red_out   <= 1'b0;              // see [RULE4]
      status_lamp_green_out <= 1'b1;
    end
  end

  // Home commit: NVM write and position zero only here, never otherwise,
  // because the memory wears out after a limited number of rewrites.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      nvm_wr_out   <= 1'b0;
      nvm_data_out <= 32'h0000_0000;
      pos_zero_out <= 1'b0;
      home_q       <= 32'h0000_0000;
    end
    else
    begin
      nvm_wr_out   <= commit;                     // see [RULE5] see [RULE11]
      pos_zero_out <= commit;                     // see [RULE12]
      if (commit)
      begin
        nvm_data_out <= motor_pos_in;             // see [RULE11]
        home_q       <= motor_pos_in;
      end
    end
  end

  // Home valid follows the NVM content after power-up, then any commit.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      home_vld_q <= 1'b0;
    else
      home_vld_q <= home_vld_q || nvm_has_home_in || commit; // see [RULE6]
  end

  // Remote jog: stop and loss of teaching win over any run request.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      jog_step_out   <= 1'b0;
      jog_run_out    <= 1'b0;
      jog_dir_out    <= 1'b0;
      jog_fast_out   <= 1'b0;
      jog_travel_out <= hps_pkg::TRAVEL_RST;
      stop_out       <= 1'b0;
      excite_off_out <= 1'b0;
    end
    else
    begin
      excite_off_out <= ctrl_q[hps_pkg::CTRL_FREE];   // see [RULE10]
      jog_fast_out   <= ctrl_q[hps_pkg::CTRL_FAST];   // see [RULE8]
      jog_travel_out <= travel_q;
      jog_step_out   <= 1'b0;
      stop_out       <= cmd[hps_pkg::CMD_STOP];        // see [RULE9]
      if (cmd[hps_pkg::CMD_STOP] || !ctrl_q[hps_pkg::CTRL_TEACH] ||
          ctrl_q[hps_pkg::CTRL_FREE])
        jog_run_out <= 1'b0;                          // see [RULE9]
      else if (cmd[hps_pkg::CMD_STEP_P] || cmd[hps_pkg::CMD_STEP_N])
      begin
        jog_step_out <= 1'b1;                         // see [RULE8]
        jog_run_out  <= 1'b0;
        jog_dir_out  <= cmd[hps_pkg::CMD_STEP_P];
      end
      else if (cmd[hps_pkg::CMD_RUN_P] || cmd[hps_pkg::CMD_RUN_N])
      begin
        jog_run_out <= 1'b1;                          // see [RULE8]
        jog_dir_out <= cmd[hps_pkg::CMD_RUN_P];
      end
    end
  end

  // Checks.
  sequence s_press_ok;
    seq_q == hps_pkg::SQ_PRESS && btn_in && !tmr_done;
  endsequence

  sequence s_commit_out;
    nvm_wr_out && pos_zero_out ##1 !nvm_wr_out;
  endsequence

  a_hold_arms: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // see [RULE1]
    seq_q == hps_pkg::SQ_HOLD && btn_in && tmr_done |=> seq_q == hps_pkg::SQ_REL)
    else $error("hold did not arm");

  a_press_commits: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // see [RULE2]
    s_press_ok |=> s_commit_out)
    else $error("second press did not commit");

  a_show_steady: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // see [RULE3]
    $rose(seq_q == hps_pkg::SQ_SHOW) |-> status_lamp_red_out && status_lamp_green_out)
    else $error("commit lamp not steady both");

  a_window_abort: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // see [RULE4]
    seq_q == hps_pkg::SQ_REL && tmr_done && !ctrl_q[hps_pkg::CTRL_TEACH]
    |=> seq_q == hps_pkg::SQ_LOCK && !nvm_wr_out
    ##1 !status_lamp_red_out && status_lamp_green_out)
    else $error("expired window did not abort");

  a_nvm_cause: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // see [RULE5]
    nvm_wr_out |-> $past(commit) && nvm_data_out == $past(motor_pos_in))
    else $error("nvm write without commit");

  a_teach_blink: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // see [RULE7]
    ctrl_q[hps_pkg::CTRL_TEACH] && seq_q == hps_pkg::SQ_IDLE && seq_d == hps_pkg::SQ_IDLE
    |=> status_lamp_red_out == status_lamp_green_out)
    else $error("teaching lamp not blinking together");

  a_step_once: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // see [RULE8]
    cmd[hps_pkg::CMD_STEP_P] && !cmd[hps_pkg::CMD_STOP] && ctrl_q == 3'h1
    |=> jog_step_out && jog_dir_out ##1 !jog_step_out)
    else $error("step jog not a single move");

  a_stop_halts: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // see [RULE9]
    cmd[hps_pkg::CMD_STOP] |=> !jog_run_out && stop_out)
    else $error("stop did not halt");

  a_free_excite: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // see [RULE10]
    ##1 excite_off_out == $past(ctrl_q[hps_pkg::CTRL_FREE]))
    else $error("excitation does not follow release");

  a_preset_zero: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // see [RULE11]
    cmd[hps_pkg::CMD_PRESET] && ctrl_q[hps_pkg::CTRL_TEACH] |=> s_commit_out)
    else $error("remote preset did not commit");

endmodule

/* hw/hps_pkg.sv */
// Shared constants for the home preset sequencer: timing, register map, fields.
// Assumes a 10 MHz core clock and a 32-bit Avalon-MM slave with byte addresses.
//
// Functional notes
// [RULE1] One-second button hold arms; both lamp colours blink.
// [RULE2] Release within 3 s, re-press within 3 s.
// [RULE3] Commit lights both steady, then green only.
// [RULE4] Window expiry aborts, steady green, re-arm needs hold.
// [RULE5] Home stored in NVM only on deliberate commits.
// [RULE6] Home survives power loss; absent when shipped.
// [RULE7] Remote teaching enabled blinks red and green together.
// [RULE8] Step jog moves min travel; run jog uses speed.
// [RULE9] Remote stop halts any motion immediately.
// [RULE10] Excitation release frees shaft; clearing re-excites.
// [RULE11] Remote preset adopts present position, writes NVM.
// [RULE12] Any commit zeroes the command position counter.
package hps_pkg;

  // Core clock rate and derived cycles per millisecond.
  localparam int unsigned CLK_HZ     = 32'h0098_9680;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 32'h0000_03E8;

  // Times in milliseconds, as specified or chosen for indication.
  localparam int unsigned HOLD_MS  = 32'h0000_03E8; // One second arming hold.
  localparam int unsigned WIN_MS   = 32'h0000_0BB8; // Three second windows.
  localparam int unsigned BLINK_MS = 32'h0000_00FA; // Half period of the blink.
  localparam int unsigned SHOW_MS  = 32'h0000_01F4; // Both-steady commit show.

  // Register byte offsets.
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_CMD    = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_TRAVEL = 5'h0C;
  localparam logic [4:0] OFS_HOME   = 5'h10;

  // Control register fields.
  localparam int unsigned CTRL_TEACH = 0; // Remote teaching enabled.
  localparam int unsigned CTRL_FREE  = 1; // Excitation released.
  localparam int unsigned CTRL_FAST  = 2; // Continuous jog at high speed.

  // Command register fields, each a self-clearing strobe.
  localparam int unsigned CMD_STEP_P = 0;
  localparam int unsigned CMD_STEP_N = 1;
  localparam int unsigned CMD_RUN_P  = 2;
  localparam int unsigned CMD_RUN_N  = 3;
  localparam int unsigned CMD_STOP   = 4;
  localparam int unsigned CMD_PRESET = 5;

  // Status register fields.
  localparam int unsigned ST_HOME  = 0;
  localparam int unsigned ST_RUN   = 1;
  localparam int unsigned ST_ARMED = 2;
  localparam int unsigned ST_FREE  = 3;

  // Reset values.
  localparam logic [31:0] TRAVEL_RST = 32'h0000_0001;

  // Button sequencer states, one-hot.
  typedef enum logic [5:0] {
    SQ_IDLE  = 6'h01, // Waiting for a press.
    SQ_HOLD  = 6'h02, // Counting the one-second hold.
    SQ_REL   = 6'h04, // Armed, waiting for release.
    SQ_PRESS = 6'h08, // Released, waiting for the second press.
    SQ_SHOW  = 6'h10, // Commit indication, both steady.
    SQ_LOCK  = 6'h20  // After an abort or a commit show, waiting for the button to go up.
  } hps_seq_t;

endpackage

/* hw/hps_timer.sv */
// Elapsed-cycle timer that restarts on a clear and flags a reached limit.
// Assumes the limit is steady while a period runs.
module hps_timer #(
  parameter int unsigned CNT_W = 28
) (
  input  wire logic             core_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             clr_in,
  input  wire logic [CNT_W-1:0] lim_in,
  output logic                  done_out
);

  logic [CNT_W-1:0] cnt_q; // Cycles since the last clear, saturating.

  // The count saturates so a long wait never wraps back under the limit.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cnt_q <= '0;
    else if (clr_in)
      cnt_q <= '0;
    else if (cnt_q != '1)
      cnt_q <= cnt_q + CNT_W'(1);
  end

  // Done in the last cycle of the period, once lim_in - 1 cycles have passed since the clear.
  assign done_out = (cnt_q >= lim_in - CNT_W'(1));

endmodule

/* verif/hps_nvm_model.sv */
// Behavioural model of the non-volatile home store beside the sequencer.
// Assumes the design writes it with a one-cycle strobe on the core clock.
module hps_nvm_store (
  input  wire logic        core_clk_in,
  input  wire logic        wr_in,
  input  wire logic [31:0] data_in,
  output logic             has_home_out,
  output logic [31:0]      home_out,
  output int unsigned      writes_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // No reset input: contents survive a power cycle, and start empty when shipped.
  initial
  begin
    has_home_out = 1'b0;
    home_out     = 32'h0000_0000;
    writes_out   = 0;
  end

  // Each strobe is one rewrite; the count lets the bench spot stray writes.
  always @(posedge core_clk_in)
  begin
    if (wr_in === 1'b1)
    begin
      has_home_out <= 1'b1;
      home_out     <= data_in;
      writes_out   <= writes_out + 1;
    end
  end
endmodule

/* verif/testbench.sv */
// Self-checking bench for the home preset sequencer: button sequence, bus.
// Assumes shortened timing parameters and an NVM store model on the far side.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned HOLD = 20; // Shortened hold, in cycles.
  localparam int unsigned WIN  = 40; // Shortened window, in cycles.
  localparam int unsigned SHOW = 10; // Shortened commit show, in cycles.
  localparam logic [31:0] ONE  = 32'h0000_0001;
  localparam logic [31:0] ZERO = 32'h0000_0000;

  logic        core_clk, arst_n, rd, wr, btn, wreq, nvm_wr, zero, step, run, dir;
  logic        fast, stop, free, red, green, has_home;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, pos, nvm_data, trav, home_nvm, tmp, last_trav;
  int unsigned nvm_writes;
  int          num_errors, checked, cyc_cnt, n_step, n_stop, n_zero;
  logic        last_dir;

  hps_home_preset #(.HOLD_CYC(HOLD), .WIN_CYC(WIN), .BLINK_CYC(4), .SHOW_CYC(SHOW))
    hps_home_preset_inst (
    .core_clk_in(core_clk), .arst_n_in(arst_n), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .btn_in(btn),
    .nvm_has_home_in(has_home), .motor_pos_in(pos), .nvm_wr_out(nvm_wr),
    .nvm_data_out(nvm_data), .pos_zero_out(zero), .jog_step_out(step),
    .jog_run_out(run), .jog_dir_out(dir), .jog_fast_out(fast),
    .jog_travel_out(trav), .stop_out(stop), .excite_off_out(free),
    .status_lamp_red_out(red), .status_lamp_green_out(green));

  hps_nvm_store hps_nvm_store_inst (
    .core_clk_in(core_clk), .wr_in(nvm_wr), .data_in(nvm_data),
    .has_home_out(has_home), .home_out(home_nvm), .writes_out(nvm_writes));

  // 10 MHz core clock.
  always #50 core_clk = ~core_clk;

  // Pulses last one cycle, so they are counted at every edge rather than polled.
  always @(posedge core_clk)
  begin
    cyc_cnt++;
    if (step === 1'b1)
    begin
      n_step++;
      last_dir  = dir;
      last_trav = trav;
    end
    if (stop === 1'b1) n_stop++;
    if (zero === 1'b1) n_zero++;
    if (cyc_cnt == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One bus access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic is_wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    rd    <= ~is_wr;
    wr    <= is_wr;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    tmp = rdata;
    rd  <= 1'b0;
    wr  <= 1'b0;
    if (n >= 50) chk("waitrequest", ONE, ZERO);
  endtask

  // Both lamp elements must match and must be toggling.
  task automatic blink_chk;
    int diff, tog;
    logic prev;
    diff = 0;
    tog  = 0;
    // The lamp answers one edge after the change that starts the blinking.
    @(posedge core_clk);
    prev = red;
    repeat (12)
    begin
      @(posedge core_clk);
      if (red !== green) diff++;
      if (red !== prev) tog++;
      prev = red;
    end
    chk("lamp_pair", 32'(diff), ZERO);
    chk("lamp_toggle", 32'(tog > 0), ONE);
  endtask

  task automatic lamps(input logic r, input logic g);
    chk("lamp_red", 32'(red), 32'(r));
    chk("lamp_green", 32'(green), 32'(g));
  endtask

  // Presses the button, holds it for the given cycles, then reads the status.
  task automatic arm(input int hold);
    btn <= 1'b1;
    cyc(hold);
    bus(1'b0, hps_pkg::OFS_STATUS, ZERO);
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    core_clk   = 1'b0;
    arst_n     = 1'b0;
    rd         = 1'b0;
    wr         = 1'b0;
    btn        = 1'b0;
    addr       = 5'h00;
    wdata      = ZERO;
    pos        = 32'h0000_1234;
    num_errors = 0;
    checked    = 0;
    cyc_cnt    = 0;
    n_step     = 0;
    n_stop     = 0;
    n_zero     = 0;
    cyc(12);
    arst_n <= 1'b1;
    cyc(1);
    lamps(1'b0, 1'b1);
    chk("excite_off", 32'(free), ZERO);
    bus(1'b0, hps_pkg::OFS_STATUS, ZERO);
    chk("home_valid", 32'(tmp[hps_pkg::ST_HOME]), ZERO);
    bus(1'b0, 5'h14, ZERO);
    chk("unmapped", tmp, ZERO);
    bus(1'b0, hps_pkg::OFS_TRAVEL, ZERO);
    chk("travel_rst", tmp, hps_pkg::TRAVEL_RST);
    // A hold just short of the limit must not arm.
    arm(HOLD - 4);
    chk("armed_short", 32'(tmp[hps_pkg::ST_ARMED]), ZERO);
    btn <= 1'b0;
    cyc(3);
    // Full sequence: hold, blink, release, press again.
    arm(HOLD + 3);
    chk("armed", 32'(tmp[hps_pkg::ST_ARMED]), ONE);
    blink_chk();
    btn <= 1'b0;
    cyc(5);
    pos <= 32'h0000_5A5A;
    btn <= 1'b1;
    cyc(4);
    btn <= 1'b0;
    chk("nvm_writes", 32'(nvm_writes), ONE);
    chk("nvm_home", home_nvm, 32'h0000_5A5A);
    chk("zero_cnt", 32'(n_zero), ONE);
    lamps(1'b1, 1'b1);
    cyc(SHOW + 2);
    lamps(1'b0, 1'b1);
    bus(1'b0, hps_pkg::OFS_HOME, ZERO);
    chk("home_reg", tmp, 32'h0000_5A5A);
    // Second window runs out before the re-press.
    arm(HOLD + 3);
    btn <= 1'b0;
    cyc(WIN + 6);
    lamps(1'b0, 1'b1);
    btn <= 1'b1;
    cyc(4);
    btn <= 1'b0;
    cyc(3);
    // First window runs out with the button still down; a short re-press must not commit.
    arm(HOLD + WIN + 8);
    chk("armed_abort", 32'(tmp[hps_pkg::ST_ARMED]), ZERO);
    btn <= 1'b0;
    cyc(2);
    btn <= 1'b1;
    cyc(4);
    btn <= 1'b0;
    cyc(3);
    chk("abort_writes", 32'(nvm_writes), ONE);
    // Remote teaching.
    bus(1'b1, hps_pkg::OFS_CTRL, ONE);
    blink_chk();
    bus(1'b1, hps_pkg::OFS_TRAVEL, 32'h0000_0010);
    bus(1'b1, hps_pkg::OFS_CMD, ONE << hps_pkg::CMD_STEP_P);
    cyc(3);
    chk("step_p", {30'(n_step), last_dir, 1'b0}, 32'h0000_0006);
    chk("step_trav", last_trav, 32'h0000_0010);
    bus(1'b1, hps_pkg::OFS_CMD, ONE << hps_pkg::CMD_STEP_N);
    cyc(3);
    chk("step_n", {30'(n_step), last_dir, 1'b0}, 32'h0000_0008);
    bus(1'b1, hps_pkg::OFS_CTRL, 32'h0000_0005);
    bus(1'b0, hps_pkg::OFS_CTRL, ZERO);
    chk("ctrl_rd", tmp, 32'h0000_0005);
    bus(1'b1, hps_pkg::OFS_CMD, ONE << hps_pkg::CMD_RUN_P);
    cyc(3);
    chk("run_p", {29'(0), run, dir, fast}, 32'h0000_0007);
    bus(1'b0, hps_pkg::OFS_STATUS, ZERO);
    chk("st_run", 32'(tmp[hps_pkg::ST_RUN]), ONE);
    bus(1'b1, hps_pkg::OFS_CMD, ONE << hps_pkg::CMD_STOP);
    cyc(3);
    chk("stop", {30'(n_stop), run, 1'b0}, 32'h0000_0004);
    bus(1'b1, hps_pkg::OFS_CTRL, ONE);
    bus(1'b1, hps_pkg::OFS_CMD, ONE << hps_pkg::CMD_RUN_N);
    cyc(3);
    chk("run_n", {29'(0), run, dir, fast}, 32'h0000_0004);
    bus(1'b1, hps_pkg::OFS_CMD, 32'h0000_0011);
    cyc(3);
    chk("stop_step", {28'(n_stop), 3'(n_step), run}, 32'h0000_0024);
    bus(1'b1, hps_pkg::OFS_CTRL, 32'h0000_0003);
    cyc(2);
    chk("free_on", 32'(free), ONE);
    bus(1'b0, hps_pkg::OFS_STATUS, ZERO);
    chk("st_free", 32'(tmp[hps_pkg::ST_FREE]), ONE);
    bus(1'b1, hps_pkg::OFS_CTRL, ONE);
    cyc(2);
    chk("free_off", 32'(free), ZERO);
    pos <= 32'h0000_0777;
    bus(1'b1, hps_pkg::OFS_CMD, ONE << hps_pkg::CMD_PRESET);
    cyc(3);
    chk("preset_wr", 32'(nvm_writes), 32'h0000_0002);
    chk("preset_home", home_nvm, 32'h0000_0777);
    chk("preset_zero", 32'(n_zero), 32'h0000_0002);
    // With teaching off, preset and step commands are refused.
    bus(1'b1, hps_pkg::OFS_CTRL, ZERO);
    bus(1'b1, hps_pkg::OFS_CMD, 32'h0000_0021);
    cyc(3);
    chk("teach_off", {28'(nvm_writes), 4'(n_step)}, 32'h0000_0022);
    // Power cycle: the stored home is still reported.
    arst_n <= 1'b0;
    cyc(3);
    arst_n <= 1'b1;
    bus(1'b0, hps_pkg::OFS_STATUS, ZERO);
    cyc(2);
    bus(1'b0, hps_pkg::OFS_STATUS, ZERO);
    chk("home_kept", 32'(tmp[hps_pkg::ST_HOME]), ONE);
    stop_test();
  end
endmodule
